// >>> hdl/clock_ctrl_pkg.sv
// Shared constants, codes and delay lookups for the clock and start-up controller
package clock_ctrl_pkg;

    // Register byte offsets on the APB
    localparam logic [11:0] STATUS_OFFSET   = 12'h000;
    localparam logic [11:0] CONTROL_OFFSET  = 12'h004;
    localparam logic [11:0] TRIM_OFFSET     = 12'h008;
    localparam logic [11:0] PRESCALE_OFFSET = 12'h00c;

    // Field positions
    localparam int CONTROL_SLEEP_BIT = 0;
    localparam int CONTROL_MODE_LSB  = 1;
    localparam int PRESCALE_PCE_BIT  = 7;

    // Source-select codes, fuse bit programmed reads as zero
    localparam logic [3:0] SRC_EXTERNAL = 4'h0;
    localparam logic [3:0] SRC_RC_4MHZ  = 4'h2;
    localparam logic [3:0] SRC_RC_8MHZ  = 4'h4;
    localparam logic [3:0] SRC_WDT_OSC  = 4'h6;
    localparam logic [3:0] SRC_CRYSTAL  = 4'h8;

    // Values as delivered
    localparam logic [3:0] DEFAULT_SOURCE_SELECT  = 4'h4;
    localparam logic [1:0] DEFAULT_STARTUP_SELECT = 2'h2;
    localparam logic       FUSE_PROGRAMMED        = 1'b0;

    // Prescaler
    localparam logic [3:0] PRESCALE_DIV1     = 4'h0;
    localparam logic [3:0] PRESCALE_DIV8     = 4'h3;
    localparam logic [3:0] PRESCALE_MAX      = 4'h8;
    localparam logic [2:0] PCE_WINDOW_CYCLES = 3'h4;

    // Start-up counts in source clock cycles
    localparam logic [14:0] RESET_SOURCE_CYCLES = 15'h000e;
    localparam logic [14:0] WAIT_6_CK           = 15'h0006;
    localparam logic [14:0] WAIT_258_CK         = 15'h0102;
    localparam logic [14:0] WAIT_1K_CK          = 15'h0400;

    typedef enum logic [1:0] {
        DELAY_NONE  = 2'b00,
        DELAY_SHORT = 2'b01,
        DELAY_LONG  = 2'b10
    } delay_class_t;

    typedef enum logic [1:0] {
        WAIT_SIX     = 2'b00,
        WAIT_258     = 2'b01,
        WAIT_1K      = 2'b10,
        WAIT_16K     = 2'b11
    } wait_class_t;

    typedef enum logic [1:0] {
        SLEEP_IDLE       = 2'b00,
        SLEEP_POWER_DOWN = 2'b01,
        SLEEP_STANDBY    = 2'b10
    } sleep_mode_t;

    // Extra reset delay in watchdog oscillator cycles
    function automatic delay_class_t reset_delay_class(input logic [3:0] src,
                                                       input logic [1:0] sut,
                                                       input logic       rst_dis);
        delay_class_t c;
        c = DELAY_LONG;
        if (src[3]) begin
            unique case ({src[0], sut})
                3'b000: c = DELAY_SHORT;
                3'b001: c = DELAY_LONG;
                3'b010: c = DELAY_NONE;
                3'b011: c = DELAY_SHORT;
                3'b100: c = DELAY_LONG;
                3'b101: c = DELAY_NONE;
                3'b110: c = DELAY_SHORT;
                3'b111: c = DELAY_LONG;
            endcase
        end else begin
            unique case (sut)
                2'b00: c = rst_dis ? DELAY_SHORT : DELAY_NONE;
                2'b01: c = DELAY_SHORT;
                2'b10: c = DELAY_LONG;
                2'b11: c = DELAY_LONG;
            endcase
        end
        return c;
    endfunction : reset_delay_class

    // Wake-up wait from power-down in source clock cycles
    function automatic wait_class_t wake_wait_class(input logic [3:0] src,
                                                    input logic [1:0] sut);
        wait_class_t w;
        w = WAIT_SIX;
        if (src[3]) begin
            if (!src[0]) begin
                w = sut[1] ? WAIT_1K : WAIT_258;
            end else begin
                w = (sut == 2'b00) ? WAIT_1K : WAIT_16K;
            end
        end
        return w;
    endfunction : wake_wait_class

endpackage : clock_ctrl_pkg

// >>> hdl/tick_counter.sv
// Down-counter advanced by a one-cycle tick, used for all start-up waits
`timescale 1ns/1ps
`default_nettype none

module tick_counter (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        load,
    input  wire logic [14:0] load_value,
    input  wire logic        tick,
    output var  logic        done
);

    logic [14:0] remaining;
    wire         at_last = (remaining == 15'h0001);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remaining <= 15'h0000;
            done      <= 1'b0;
        end else if (load) begin
            remaining <= load_value;
            done      <= (load_value == 15'h0000);
        end else if (tick && remaining != 15'h0000) begin
            remaining <= remaining - 15'h0001;
            done      <= at_last;
        end
    end

endmodule : tick_counter

`default_nettype wire

// >>> hdl/clock_source_startup_control.sv
// Clock source selection, start-up sequencing, prescaler and domain gating
// Function
// - Source chosen from 4-bit select: external, RC 4 or 8 MHz, watchdog, crystal
// - Fuse bits read one unprogrammed, zero programmed
// - Power-down wake waits configured source clock cycles before execution
// - Reset adds none, 512 or 8192 watchdog oscillator cycles
// - Delivered: select 0100, start-up 10, divide-by-eight programmed
// - Crystal range taken from upper three select bits
// - Crystal low bit 0: waits 258/258/1K/1K, delays short/long/none/short
// - Crystal low bit 1: 1K long, then 16K none/short/long
// - Divide-by-eight fuse programmed divides clock by 8 from start-up
// - Calibration byte copied into trim register on every reset
// - Reset time-out timed by watchdog oscillator even on RC clock
// - RC source: 6 CK wait, delays none/short/long, code 11 reserved
// - RC code 00 with reset-pin-disable programmed gets short delay
// - Core and flash domains gated together, I/O domain separately, by sleep mode
// - External and serial start wake sources work with I/O clock halted
// - Flash clock runs together with core clock
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module clock_source_startup_control #(
    parameter logic [14:0] SHORT_DELAY_CYCLES = 15'h0200,
    parameter logic [14:0] LONG_DELAY_CYCLES  = 15'h2000,
    parameter logic [14:0] WAIT_16K_CYCLES    = 15'h4000
) (
    input  wire logic        pclk,
    input  wire logic        presetn,

    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,

    input  wire logic [3:0]  clock_source_select,
    input  wire logic [1:0]  startup_time_select,
    input  wire logic        divide_by_eight_fuse,
    input  wire logic        reset_pin_disable_fuse,

    input  wire logic [7:0]  calibration_byte,

    input  wire logic        source_clock_tick,
    input  wire logic        watchdog_osc_tick,

    input  wire logic        ext_int_wake,
    input  wire logic        serial_start_wake,
    input  wire logic        io_int_wake,

    output var  logic        core_clock_enable,
    output var  logic        io_clock_enable,
    output var  logic        flash_clock_enable,
    output var  logic        system_clock_tick,
    output var  logic        execution_enable,

    output var  logic [1:0]  source_kind,
    output var  logic [2:0]  crystal_range,
    output var  logic        crystal_enable,
    output var  logic        rc_enable,
    output var  logic        rc_high_frequency,
    output var  logic [7:0]  oscillator_trim_value
);

    typedef enum logic [2:0] {
        ST_CAPTURE     = 3'b000,
        ST_RESET_CK    = 3'b001,
        ST_RESET_WDT   = 3'b010,
        ST_RUN         = 3'b011,
        ST_SLEEP       = 3'b100,
        ST_WAKE        = 3'b101
    } state_t;

    state_t      state;
    state_t      next_state;

    // Latched fuse image
    logic [3:0]  source_select;
    logic [1:0]  startup_select;
    logic        div8_programmed;
    logic        rstdis_programmed;

    // Software state
    logic [1:0]  sleep_mode;
    logic [3:0]  prescale_division_select;
    logic        prescale_change_enable;
    logic [2:0]  pce_timer;
    logic [8:0]  prescale_count;

    // Bus decode
    wire         setup_phase  = psel && !penable;
    wire         access       = psel && penable && pready;
    wire         write_access = access && pwrite;

    wire         hit_status   = (paddr == clock_ctrl_pkg::STATUS_OFFSET);
    wire         hit_control  = (paddr == clock_ctrl_pkg::CONTROL_OFFSET);
    wire         hit_trim     = (paddr == clock_ctrl_pkg::TRIM_OFFSET);
    wire         hit_prescale = (paddr == clock_ctrl_pkg::PRESCALE_OFFSET);

    wire         hit_any      = hit_status || hit_control || hit_trim || hit_prescale;

    // Write strobes
    wire         wr_control   = write_access && hit_control;
    wire         wr_trim      = write_access && hit_trim;
    wire         wr_prescale  = write_access && hit_prescale;
    wire         sleep_request = wr_control && pwdata[clock_ctrl_pkg::CONTROL_SLEEP_BIT];

    // Prescaler write procedure
    wire         pce_only     = pwdata[clock_ctrl_pkg::PRESCALE_PCE_BIT] &&
                                (pwdata[6:0] == 7'h00);
    wire         pce_arm      = wr_prescale && pce_only && !prescale_change_enable;

    wire         div_accept   = wr_prescale && prescale_change_enable &&
                                !pwdata[clock_ctrl_pkg::PRESCALE_PCE_BIT] &&
                                (pwdata[3:0] <= clock_ctrl_pkg::PRESCALE_MAX);
    wire         pce_expire   = prescale_change_enable && (pce_timer == 3'h1);

    // Start-up lookups on the latched image
    clock_ctrl_pkg::delay_class_t reset_class;
    clock_ctrl_pkg::wait_class_t  wake_class;

    assign reset_class = clock_ctrl_pkg::reset_delay_class(source_select, startup_select,
                                                           rstdis_programmed);
    assign wake_class  = clock_ctrl_pkg::wake_wait_class(source_select, startup_select);

    wire [14:0]  reset_wdt_cycles = (reset_class == clock_ctrl_pkg::DELAY_LONG)  ?
                                    LONG_DELAY_CYCLES :
                                    (reset_class == clock_ctrl_pkg::DELAY_SHORT) ?
                                    SHORT_DELAY_CYCLES : 15'h0000;

    wire [14:0]  wake_cycles      = (wake_class == clock_ctrl_pkg::WAIT_16K) ? WAIT_16K_CYCLES :
                                    (wake_class == clock_ctrl_pkg::WAIT_1K)  ?
                                    clock_ctrl_pkg::WAIT_1K_CK :
                                    (wake_class == clock_ctrl_pkg::WAIT_258) ?
                                    clock_ctrl_pkg::WAIT_258_CK : clock_ctrl_pkg::WAIT_6_CK;

    // Shared wait counter: loads on entry to each waiting state
    wire         counter_done;

    wire         enter_reset_ck  = (state == ST_CAPTURE);
    wire         enter_reset_wdt = (state == ST_RESET_CK) && counter_done;
    wire         wake_event      = ext_int_wake || serial_start_wake ||
                                   (io_int_wake && sleep_mode == clock_ctrl_pkg::SLEEP_IDLE);
    // Only power-down needs the source to settle
    wire         enter_wake      = (state == ST_SLEEP) && wake_event &&
                                   (sleep_mode == clock_ctrl_pkg::SLEEP_POWER_DOWN);

    wire         counter_load    = enter_reset_ck || enter_reset_wdt || enter_wake;
    wire [14:0]  counter_value   = enter_reset_ck  ? clock_ctrl_pkg::RESET_SOURCE_CYCLES :
                                   enter_reset_wdt ? reset_wdt_cycles : wake_cycles;
    // Watchdog oscillator times the real-time part whatever the system source
    wire         counter_tick    = (state == ST_RESET_WDT) ? watchdog_osc_tick :
                                   source_clock_tick;

    tick_counter wait_counter (
        .pclk       (pclk),
        .presetn    (presetn),
        .load       (counter_load),
        .load_value (counter_value),
        .tick       (counter_tick),
        .done       (counter_done)
    );

    // Capture, 14 source cycles, watchdog wait, run
    always_comb begin
        next_state = state;
        unique case (state)
            ST_CAPTURE:   next_state = ST_RESET_CK;
            ST_RESET_CK:  next_state = counter_done ? ST_RESET_WDT : ST_RESET_CK;
            ST_RESET_WDT: next_state = (counter_done && !counter_load) ? ST_RUN : ST_RESET_WDT;
            ST_RUN:       next_state = sleep_request ? ST_SLEEP : ST_RUN;
            ST_SLEEP: begin
                if (enter_wake) begin
                    next_state = ST_WAKE;
                end else if (wake_event) begin
                    next_state = ST_RUN;
                end
            end
            ST_WAKE:      next_state = (counter_done && !counter_load) ? ST_RUN : ST_WAKE;
            default:      next_state = ST_CAPTURE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_CAPTURE;
        end else begin
            state <= next_state;
        end
    end

    // Fuse image is taken once after reset release, never again
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            source_select     <= clock_ctrl_pkg::DEFAULT_SOURCE_SELECT;
            startup_select    <= clock_ctrl_pkg::DEFAULT_STARTUP_SELECT;
            div8_programmed   <= 1'b1;
            rstdis_programmed <= 1'b0;
        end else if (state == ST_CAPTURE) begin
            source_select     <= clock_source_select;
            startup_select    <= startup_time_select;
            div8_programmed   <= (divide_by_eight_fuse == clock_ctrl_pkg::FUSE_PROGRAMMED);
            rstdis_programmed <= (reset_pin_disable_fuse == clock_ctrl_pkg::FUSE_PROGRAMMED);
        end
    end

    // Source decode; odd reserved codes follow their even neighbour
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            source_kind       <= 2'h2;
            crystal_range     <= 3'h0;
            crystal_enable    <= 1'b0;
            rc_enable         <= 1'b1;
            rc_high_frequency <= 1'b1;
        end else begin
            source_kind       <= source_select[3] ? 2'h3 : source_select[2:1];
            crystal_range     <= source_select[3] ? source_select[3:1] : 3'h0;
            crystal_enable    <= source_select[3];
            rc_enable         <= (source_select[3:1] == clock_ctrl_pkg::SRC_RC_4MHZ[3:1]) ||
                                 (source_select[3:1] == clock_ctrl_pkg::SRC_RC_8MHZ[3:1]);
            rc_high_frequency <= (source_select[3:1] == clock_ctrl_pkg::SRC_RC_8MHZ[3:1]);
        end
    end

    // Trim register: calibration copied in every time reset is released
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oscillator_trim_value <= 8'h00;
        end else if (state == ST_CAPTURE) begin
            oscillator_trim_value <= calibration_byte;
        end else if (wr_trim) begin
            oscillator_trim_value <= pwdata[7:0];
        end
    end

    // Mode is kept; the sleep bit is a strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_mode <= clock_ctrl_pkg::SLEEP_IDLE;
        end else if (wr_control) begin
            sleep_mode <= pwdata[clock_ctrl_pkg::CONTROL_MODE_LSB +: 2];
        end
    end

    // Prescaler change enable; rewriting it inside the window does not extend it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_change_enable <= 1'b0;
            pce_timer              <= 3'h0;
        end else if (pce_arm) begin
            prescale_change_enable <= 1'b1;
            pce_timer              <= clock_ctrl_pkg::PCE_WINDOW_CYCLES;
        end else if (div_accept || pce_expire) begin
            prescale_change_enable <= 1'b0;
            pce_timer              <= 3'h0;
        end else if (prescale_change_enable) begin
            pce_timer              <= pce_timer - 3'h1;
        end
    end

    // Fuse sets the division at each reset
    wire [3:0]   div8_next_value = (divide_by_eight_fuse == clock_ctrl_pkg::FUSE_PROGRAMMED) ?
                                   clock_ctrl_pkg::PRESCALE_DIV8 : clock_ctrl_pkg::PRESCALE_DIV1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_division_select <= clock_ctrl_pkg::PRESCALE_DIV8;
        end else if (state == ST_CAPTURE) begin
            prescale_division_select <= div8_next_value;
        end else if (div_accept) begin
            prescale_division_select <= pwdata[3:0];
        end
    end

    // Divider on source ticks; a changed division restarts the count cleanly
    wire [8:0]   prescale_limit = 9'(9'h001 << prescale_division_select) - 9'h001;
    wire         prescale_wrap  = (prescale_count >= prescale_limit);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_count <= 9'h000;
        end else if (div_accept) begin
            prescale_count <= 9'h000;
        end else if (source_clock_tick) begin
            prescale_count <= prescale_wrap ? 9'h000 : prescale_count + 9'h001;
        end
    end

    // Domain enables: idle stops core and flash, deeper modes stop all
    wire         running     = (state == ST_RUN);

    wire         io_running  = running ||
                               (state == ST_SLEEP && sleep_mode == clock_ctrl_pkg::SLEEP_IDLE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_clock_enable  <= 1'b0;
            flash_clock_enable <= 1'b0;
            io_clock_enable    <= 1'b0;
            execution_enable   <= 1'b0;
            system_clock_tick  <= 1'b0;
        end else begin
            core_clock_enable  <= running;
            flash_clock_enable <= running;
            io_clock_enable    <= io_running;
            execution_enable   <= running;
            system_clock_tick  <= source_clock_tick && prescale_wrap && io_running;
        end
    end

    // APB: no wait cycle; ready and read data come from flops loaded in the setup phase
    wire [31:0]  status_word   = {20'h00000, prescale_change_enable, state,
                                  rstdis_programmed, div8_programmed,
                                  startup_select, source_select};

    wire [31:0]  control_word  = {29'h00000000, sleep_mode, 1'b0};
    wire [31:0]  prescale_word = {24'h000000, prescale_change_enable, 3'h0,
                                  prescale_division_select};

    wire [31:0]  read_word     = hit_status   ? status_word :
                                 hit_control  ? control_word :
                                 hit_trim     ? {24'h000000, oscillator_trim_value} :
                                 hit_prescale ? prescale_word : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup_phase;
            pslverr <= setup_phase && !hit_any;
            prdata  <= (setup_phase && !pwrite) ? read_word : 32'h00000000;
        end
    end

endmodule : clock_source_startup_control

`default_nettype wire

// >>> bench/clock_ctrl_props.sv
// Port checker for the clock and start-up controller
`timescale 1ns/1ps
`default_nettype none
module clock_ctrl_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        core_clock_enable,
    input wire logic        io_clock_enable,
    input wire logic        flash_clock_enable,
    input wire logic        execution_enable
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_ready_setup: assert property (psel && !penable |=> pready) else $error("no ready");
    chk_ready_single: assert property (pready |=> !pready) else $error("long ready");
    chk_ready_cause: assert property (pready |-> psel && penable) else $error("stray ready");
    chk_err_ready: assert property (pslverr |-> pready) else $error("stray error");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("stray data");
    chk_flash_core: assert property (flash_clock_enable == core_clock_enable)
        else $error("flash clock apart");
    chk_exec_core: assert property (execution_enable == core_clock_enable)
        else $error("execution apart");
    chk_io_core: assert property (core_clock_enable |-> io_clock_enable)
        else $error("io clock halted");
    cover property (pslverr);
    cover property ($rose(execution_enable));
    cover property (io_clock_enable && !core_clock_enable);
endmodule : clock_ctrl_props

bind clock_source_startup_control clock_ctrl_props clock_ctrl_props_inst (.pclk, .presetn, .psel,
    .penable, .prdata, .pready, .pslverr, .core_clock_enable, .io_clock_enable,
    .flash_clock_enable, .execution_enable);
`default_nettype wire

// >>> bench/osc_model.sv
// Free-running source and watchdog oscillator ticks
`timescale 1ns/1ps
`default_nettype none
module osc_model (
    input  wire logic pclk,
    input  wire logic slow,
    output var  logic src_tick,
    output var  logic wdt_tick
);
    logic [1:0] src_cnt = 2'h0;
    logic [3:0] wdt_cnt = 4'h0;
    // Oscillators ignore reset, so the start-up phase is arbitrary
    always_ff @(posedge pclk) begin
        src_cnt <= (slow && src_cnt != 2'h2) ? src_cnt + 2'h1 : 2'h0;
        wdt_cnt <= (wdt_cnt == 4'h9) ? 4'h0 : wdt_cnt + 4'h1;
    end
    assign src_tick = (src_cnt == 2'h0);
    assign wdt_tick = (wdt_cnt == 4'h0);
endmodule : osc_model
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench for the clock and start-up controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        divide_by_eight_fuse = 1'b0, reset_pin_disable_fuse = 1'b1, slow = 1'b0;
    logic        ext_int_wake = 1'b0, serial_start_wake = 1'b0, io_int_wake = 1'b0;
    logic        source_clock_tick, watchdog_osc_tick, pready, pslverr, core_clock_enable;
    logic        io_clock_enable, flash_clock_enable, system_clock_tick, execution_enable;
    logic        crystal_enable, rc_enable, rc_high_frequency, err;
    logic [1:0]  startup_time_select = 2'h2, source_kind;
    logic [2:0]  crystal_range;
    logic [3:0]  clock_source_select = 4'h4;
    logic [7:0]  calibration_byte = 8'h00, oscillator_trim_value;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int          errors = 0, checked = 0, n;
    // Select, start-up code, reset-pin fuse, expected watchdog ticks
    logic [10:0] cases [15] = '{11'h258, 11'h210, 11'h204, 11'h134, 11'h034, 11'h358, 11'h414,
        11'h538, 11'h650, 11'h474, 11'h498, 11'h5b0, 11'h6c4, 11'h7f8, 11'h258};

    always #2 pclk = ~pclk;
    osc_model osc_model_inst (.pclk, .slow, .src_tick(source_clock_tick),
        .wdt_tick(watchdog_osc_tick));
    clock_source_startup_control #(.SHORT_DELAY_CYCLES(15'h0004), .LONG_DELAY_CYCLES(15'h0008),
        .WAIT_16K_CYCLES(15'h0010)) clock_source_startup_control_inst (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .clock_source_select,
        .startup_time_select, .divide_by_eight_fuse, .reset_pin_disable_fuse, .calibration_byte,
        .source_clock_tick, .watchdog_osc_tick, .ext_int_wake, .serial_start_wake, .io_int_wake,
        .core_clock_enable, .io_clock_enable, .flash_clock_enable, .system_clock_tick,
        .execution_enable, .source_kind, .crystal_range, .crystal_enable, .rc_enable,
        .rc_high_frequency, .oscillator_trim_value);

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up

    // Edges until sig is seen high; a hang ends the run
    task automatic wait_hi(ref logic sig, input int lim);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (sig !== 1'b1 && n < lim);
        if (sig !== 1'b1) begin
            errors++;
            wrap_up();
        end
    endtask : wait_hi

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        wait_hi(pready, 20);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic boot(input logic [3:0] s, input logic [1:0] t, input logic r, input int dly);
        int e;
        presetn                <= 1'b0;
        clock_source_select    <= s;
        startup_time_select    <= t;
        reset_pin_disable_fuse <= r;
        calibration_byte       <= {s, t, r, 1'b1};
        repeat (16) @(posedge pclk);
        // Wide window: watchdog phase is free-running
        e = 14 * (slow ? 3 : 1) + dly * 10;
        check("reset_out", {source_kind, rc_enable, rc_high_frequency, execution_enable}, 5'h16);
        presetn <= 1'b1;
        wait_hi(execution_enable, 400);
        check("boot_time", n > e - 12 && n < e + 16, 1'b1);
        check("kind", {source_kind, rc_enable, rc_high_frequency},
            {s[3] ? 2'h3 : s[2:1], s[3:1] inside {3'h1, 3'h2}, s[3:1] == 3'h2});
        check("xtal", {crystal_enable, crystal_range}, s[3] ? {1'b1, s[3:1]} : 4'h0);
        check("trim", oscillator_trim_value, calibration_byte);
        apb(1'b0, 12'h000, 32'h0);
        check("status", rd, {20'h0, 4'h3, ~r, ~divide_by_eight_fuse, t, s});
    endtask : boot

    task automatic boot_cases;
        foreach (cases[i]) begin
            slow <= (i == 1);
            boot(cases[i][10:7], cases[i][6:5], cases[i][4], cases[i][3:0]);
        end
    endtask : boot_cases

    task automatic sleep_wake;
        apb(1'b1, 12'h004, 32'h1);
        repeat (3) @(posedge pclk);
        check("idle_gate", {core_clock_enable, flash_clock_enable, io_clock_enable}, 3'h1);
        io_int_wake <= 1'b1;
        wait_hi(execution_enable, 6);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, 12'h004, 32'h3);
            io_int_wake <= 1'b1;
            repeat (12) @(posedge pclk);
            check("pd_gate", {execution_enable, flash_clock_enable, io_clock_enable}, 3'h0);
            {serial_start_wake, ext_int_wake} <= k ? 2'h2 : 2'h1;
            wait_hi(execution_enable, 40);
            check("pd_wake", n >= 6 && n < 14, 1'b1);
            {serial_start_wake, ext_int_wake, io_int_wake} <= 3'h0;
        end
        apb(1'b0, 12'h010, 32'h0);
        check("bad_addr", {err, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, 12'h008, 32'h0000_003c);
        apb(1'b0, 12'h008, 32'h0);
        check("trim_rw", rd, 32'h0000_003c);
    endtask : sleep_wake

    task automatic count_ticks(input int want);
        int k;
        k = 0;
        repeat (8) @(posedge pclk);
        repeat (64) begin
            @(posedge pclk);
            k += (system_clock_tick === 1'b1);
        end
        check("ticks", k >= want - 1 && k <= want + 1, 1'b1);
    endtask : count_ticks

    task automatic prescale;
        divide_by_eight_fuse <= 1'b1;
        boot(4'h4, 2'h0, 1'b1, 0);
        count_ticks(64);
        divide_by_eight_fuse <= 1'b0;
        boot(4'h4, 2'h0, 1'b1, 0);
        count_ticks(8);
        apb(1'b1, 12'h00c, 32'h80);
        apb(1'b1, 12'h00c, 32'h1);
        count_ticks(32);
        apb(1'b1, 12'h00c, 32'h80);
        repeat (8) @(posedge pclk);
        apb(1'b1, 12'h00c, 32'h3);
        apb(1'b1, 12'h00c, 32'h80);
        apb(1'b1, 12'h00c, 32'h9);
        count_ticks(32);
        apb(1'b0, 12'h00c, 32'h0);
        check("prescale", rd, 32'h1);
    endtask : prescale

    initial begin
        @(posedge pclk);
        boot_cases();
        sleep_wake();
        prescale();
        wrap_up();
    end
endmodule : tb
`default_nettype wire
